// ===== rtl/serial_node_cfg.svh
// Constants for the switch-bank configuration loader.
// Assumes inclusion by bare name from the rtl folder.
`ifndef SERIAL_NODE_CFG_SVH
`define SERIAL_NODE_CFG_SVH
`define ADDR_W          6
`define SPEED_W         2
`define SW_W            8
`define ADDR_LSB        0
`define ADDR_MSB        5
`define SPEED_LSB       6
`define SPEED_MSB       7
`define ADDR_USE_NVM    6'h00
`define SPEED_USE_NVM   2'h0
`define SPEED_9K6       2'h1
`define SPEED_38K4      2'h2
`define SPEED_115K2     2'h3
`define RATE_9K6        20'h0_2580
`define RATE_38K4       20'h0_9600
`define RATE_115K2      20'h1_C200
`define CLK_HZ          10000000
`define DEBOUNCE_NS     10000000
`define CLK_NS          100
`define DEBOUNCE_CYC    (`DEBOUNCE_NS / `CLK_NS)
`define STABLE_W        17
`endif

// ===== rtl/serial_node_pkg.sv
// Types for the switch-bank configuration loader.
// Assumes nothing of its surroundings.
package serial_node_pkg;
  typedef enum logic [1:0] {
    ST_WAIT   = 2'b00,
    ST_SETTLE = 2'b01,
    ST_HOLD   = 2'b11
  } load_state_t;
endpackage

// ===== rtl/switch_debounce.sv
// Debouncer for a bank of switches: reports when the bank has held still.
// Assumes switch inputs already synchronous to the clock.
`timescale 1ns/1ns
`include "serial_node_cfg.svh"
module switch_debounce #(
  parameter int W      = `SW_W,
  parameter int STABLE = `DEBOUNCE_CYC
) (
  input  wire logic         i_ref_clk, // System clock
  input  wire logic         i_rst_n,   // Async reset, active low
  input  wire logic [W-1:0] i_raw,     // Raw switch levels
  output logic      [W-1:0] o_clean,   // Raw levels, two cycles late
  output logic              o_stable   // High once value held STABLE cycles
);
  logic [W-1:0]         last;
  logic [`STABLE_W-1:0] count;
  wire                  same      = (i_raw == last);
  wire                  reached   = (count == `STABLE_W'(STABLE - 1));
  wire [`STABLE_W-1:0]  next_count = same ? (reached ? count : count + `STABLE_W'(1))
                                          : '0;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last     <= '0;
      count    <= '0;
      o_clean  <= '0;
      o_stable <= 1'b0;
    end else begin
      last     <= i_raw;
      count    <= next_count;
      o_clean  <= last;
      o_stable <= same && reached;
    end
  end
endmodule

// ===== rtl/serial_node_switch_config.sv
// Switch-bank decoder giving the multidrop node address and link speed.
// Assumes switch and select inputs synchronous to i_ref_clk, and a
// non-volatile store that presents its address and rate words steadily.
// The bank must stand still for the whole debounce window to be captured.
`timescale 1ns/1ns
`include "serial_node_cfg.svh"

// How it works
// - Switches one to six form the node address, switch one the low bit, on as one.
// - Switches seven and eight form the speed code, switch seven the low bit, on as one.
// - The point-to-point interface settings never depend on the switches.
// - An address of zero on the switches selects the stored address instead.
// - A speed code of zero takes the bit rate from the stored value.
// - Speed codes one, two and three give 9.6, 38.4 and 115.2 kbps.
// - Select low runs multidrop differential mode, high runs point-to-point.
module serial_node_switch_config #(
  parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYC
) (
  input  wire logic                i_ref_clk,     // 10 MHz system clock
  input  wire logic                i_rst_n,       // Async reset, active low
  input  wire logic [`SW_W-1:0]    i_switch,      // Switch bank, bit0 = switch one, 1 = on
  input  wire logic                i_select,      // Serial standard select, low = multidrop
  input  wire logic [`ADDR_W-1:0]  i_nvm_addr,    // Stored node address
  input  wire logic [19:0]         i_nvm_rate,    // Stored bit rate in bps
  input  wire logic [19:0]         i_p2p_rate,    // Point-to-point bit rate in bps
  output logic      [`ADDR_W-1:0]  o_node_addr,   // Effective node address
  output logic      [`SPEED_W-1:0] o_speed_code,  // Captured switch speed code
  output logic      [19:0]         o_bit_rate,    // Effective link bit rate in bps
  output logic                     o_multidrop,   // High in multidrop differential mode
  output logic                     o_cfg_valid    // High once configuration captured
);
  serial_node_pkg::load_state_t state;
  serial_node_pkg::load_state_t next_state;

  logic [`SW_W-1:0]    clean;
  logic                stable;
  logic [`ADDR_W-1:0]  sw_addr;
  logic [`SPEED_W-1:0] sw_speed;

  // Debounce window sets the earliest capture edge after release
  switch_debounce #(
    .W      (`SW_W),
    .STABLE (DEBOUNCE_CYCLES)
  ) u_debounce (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_raw     (i_switch),
    .o_clean   (clean),
    .o_stable  (stable)
  );

  wire [`ADDR_W-1:0]  dec_addr  = clean[`ADDR_MSB:`ADDR_LSB];
  wire [`SPEED_W-1:0] dec_speed = clean[`SPEED_MSB:`SPEED_LSB];

  // Capture only in SETTLE, so a bank change after HOLD never reloads
  wire capture = (state == serial_node_pkg::ST_SETTLE) && stable;

  always_comb begin
    next_state = state;
    case (state)
      serial_node_pkg::ST_WAIT:   next_state = serial_node_pkg::ST_SETTLE;
      serial_node_pkg::ST_SETTLE: if (stable) next_state = serial_node_pkg::ST_HOLD;
      serial_node_pkg::ST_HOLD:   next_state = serial_node_pkg::ST_HOLD;
      default:                    next_state = serial_node_pkg::ST_WAIT;
    endcase
  end

  // Zero address falls back to store
  wire [`ADDR_W-1:0] eff_addr = (sw_addr == `ADDR_USE_NVM) ? i_nvm_addr : sw_addr;

  // Stored rate passes live, so a store update needs no reset
  // Speed code to bit rate
  logic [19:0] md_rate;
  always_comb begin
    case (sw_speed)
      `SPEED_9K6:   md_rate = `RATE_9K6;
      `SPEED_38K4:  md_rate = `RATE_38K4;
      `SPEED_115K2: md_rate = `RATE_115K2;
      default:      md_rate = i_nvm_rate;
    endcase
  end

  wire multidrop = !i_select;
  wire [19:0] next_rate = multidrop ? md_rate : i_p2p_rate;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state    <= serial_node_pkg::ST_WAIT;
      sw_addr  <= '0;
      sw_speed <= '0;
    end else begin
      state <= next_state;
      if (capture) begin
        sw_addr  <= dec_addr;
        sw_speed <= dec_speed;
      end
    end
  end

  // Every output registered; fallback values follow the store a cycle late
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_node_addr  <= '0;
      o_speed_code <= '0;
      o_bit_rate   <= '0;
      o_multidrop  <= 1'b0;
      o_cfg_valid  <= 1'b0;
    end else begin
      o_node_addr  <= eff_addr;
      o_speed_code <= sw_speed;
      o_bit_rate   <= next_rate;
      o_multidrop  <= multidrop;
      o_cfg_valid  <= (state == serial_node_pkg::ST_HOLD);
    end
  end

  // Outputs still hold reset values at the release edge, so the sampled
  // reset level qualifies every one-cycle output check except a_valid_sticky
  sequence s_held;
    o_cfg_valid && $past(o_cfg_valid);
  endsequence

  a_addr_stable_hold: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_held |-> $stable(sw_addr) && $stable(sw_speed))
    else $error("Captured switches changed after capture");

  a_addr_nvm_fallback: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && sw_addr == `ADDR_USE_NVM) |=> o_node_addr == $past(i_nvm_addr))
    else $error("Zero address did not use stored address");

  a_addr_switch_use: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && sw_addr != `ADDR_USE_NVM) |=> o_node_addr == $past(sw_addr))
    else $error("Switch address not passed out");

  a_capture_bits: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    capture |=> sw_speed == $past(clean[`SPEED_MSB:`SPEED_LSB])
             && sw_addr == $past(clean[`ADDR_MSB:`ADDR_LSB]))
    else $error("Switch fields captured wrongly");

  a_rate_nvm_path: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && multidrop && sw_speed == `SPEED_USE_NVM) |=> o_bit_rate == $past(i_nvm_rate))
    else $error("Zero speed code did not use stored rate");

  a_rate_fixed_map: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && multidrop && sw_speed == `SPEED_115K2) |=> o_bit_rate == `RATE_115K2)
    else $error("Speed code three not 115.2 kbps");

  a_p2p_rate_pass: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && !multidrop) |=> o_bit_rate == $past(i_p2p_rate))
    else $error("Point-to-point rate depends on switches");

  a_mode_select: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rst_n |=> o_multidrop == !$past(i_select))
    else $error("Mode does not follow select");

  a_p2p_mode_flag: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && i_select) |=> !o_multidrop)
    else $error("Select high still shows multidrop");

  a_speed_code_out: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_rst_n |=> o_speed_code == $past(sw_speed))
    else $error("Speed code output not the captured code");

  a_rate_low_map: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && multidrop && sw_speed == `SPEED_9K6) |=> o_bit_rate == `RATE_9K6)
    else $error("Speed code one not 9.6 kbps");

  a_rate_mid_map: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && multidrop && sw_speed == `SPEED_38K4) |=> o_bit_rate == `RATE_38K4)
    else $error("Speed code two not 38.4 kbps");

  // First edge after release leaves WAIT for SETTLE
  a_state_wait_exit: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && state == serial_node_pkg::ST_WAIT) |=> state == serial_node_pkg::ST_SETTLE)
    else $error("Loader did not leave the wait state");

  a_state_hold_stays: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (state == serial_node_pkg::ST_HOLD) |=> state == serial_node_pkg::ST_HOLD)
    else $error("Loader left the hold state without reset");

  // Bank must have stood still over the last sampled cycles
  a_capture_debounced: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    capture |-> $stable(clean) && clean == $past(clean, 2))
    else $error("Capture taken from a moving bank");

  // Load steps: capture, then the hold state, then the valid flag
  sequence s_capture_seen;
    capture ##1 (state == serial_node_pkg::ST_HOLD);
  endsequence

  a_valid_after_load: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_capture_seen |=> o_cfg_valid)
    else $error("Valid flag missing after capture");

  a_valid_sticky: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_cfg_valid |=> o_cfg_valid)
    else $error("Valid flag dropped before reset");

  a_no_valid_early: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_rst_n && state != serial_node_pkg::ST_HOLD) |=> !o_cfg_valid)
    else $error("Valid flag raised before capture");

  // Loads since reset; a second one would reconfigure a running link.
  // Saturates so a fault cannot wrap back to a legal count.
  logic [1:0] load_count;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      load_count <= '0;
    end else if (capture && load_count != 2'h3) begin
      load_count <= load_count + 2'h1;
    end
  end

  a_capture_single: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    load_count <= 2'h1)
    else $error("Switch bank loaded more than once");
endmodule

// ===== sim/switch_nvm_model.sv
// Model of the switch bank and the stored-parameter memory beside the decoder.
// Assumes the bench sets the bank level and picks which stored set is shown.
`timescale 1ns/1ns
module switch_nvm_model #(
  parameter logic [5:0]  ADDR_A = 6'h2A,
  parameter logic [5:0]  ADDR_B = 6'h15,
  parameter logic [19:0] RATE_A = 20'h0_4B00,
  parameter logic [19:0] RATE_B = 20'h0_E100
) (
  input  wire logic        i_ref_clk,  // System clock
  input  wire logic [7:0]  i_setting,  // Requested bank levels
  input  wire logic        i_alt,      // Show the second stored set
  output logic      [7:0]  o_switch,   // Bank levels, clock synchronous
  output logic      [5:0]  o_nvm_addr, // Stored node address
  output logic      [19:0] o_nvm_rate  // Stored bit rate
);
  // Re-timed so the decoder never sees a level change mid-cycle
  always_ff @(posedge i_ref_clk) o_switch <= i_setting;
  assign o_nvm_addr = i_alt ? ADDR_B : ADDR_A;
  assign o_nvm_rate = i_alt ? RATE_B : RATE_A;
endmodule

// ===== sim/serial_node_switch_config_tb.sv
// Self-checking bench for the switch-bank decoder.
// Assumes a short debounce count so each capture takes a few cycles.
`timescale 1ns/1ns
module serial_node_switch_config_tb;
  logic        i_ref_clk  = 1'b0;
  logic        i_rst_n    = 1'b0;
  logic        i_select   = 1'b0;
  logic        alt        = 1'b0;
  logic [7:0]  sw_set     = 8'h00;
  logic [19:0] i_p2p_rate = 20'h1_2C00;
  logic [7:0]  i_switch;
  logic [5:0]  i_nvm_addr, o_node_addr;
  logic [19:0] i_nvm_rate, o_bit_rate;
  logic [1:0]  o_speed_code;
  logic        o_multidrop, o_cfg_valid;
  int          fails = 0, total_checks = 0, cycles = 0;
  logic [19:0] rate_of [4] = '{20'h0_0000, 20'h0_2580, 20'h0_9600, 20'h1_C200};

  switch_nvm_model PM (.i_ref_clk(i_ref_clk), .i_setting(sw_set), .i_alt(alt),
    .o_switch(i_switch), .o_nvm_addr(i_nvm_addr), .o_nvm_rate(i_nvm_rate));
  serial_node_switch_config #(.DEBOUNCE_CYCLES(8)) DUT (.i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n), .i_switch(i_switch), .i_select(i_select),
    .i_nvm_addr(i_nvm_addr), .i_nvm_rate(i_nvm_rate), .i_p2p_rate(i_p2p_rate),
    .o_node_addr(o_node_addr), .o_speed_code(o_speed_code), .o_bit_rate(o_bit_rate),
    .o_multidrop(o_multidrop), .o_cfg_valid(o_cfg_valid));

  initial forever #50 i_ref_clk = ~i_ref_clk;

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge i_ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      end_of_test();
    end
  end

  task automatic check(input logic [19:0] seen, input logic [19:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Reset with a bank setting, wait for capture, return at a falling edge
  task automatic restart(input logic [7:0] sw);
    @(posedge i_ref_clk);
    i_rst_n  <= 1'b0;
    sw_set   <= sw;
    i_select <= 1'b0;
    alt      <= 1'b0;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_ref_clk);
      if (o_cfg_valid === 1'b1) break;
    end
    check({19'h0, o_cfg_valid}, 20'h0_0001); // capture done
  endtask

  task automatic decode_codes();
    logic [5:0] adr;
    for (int c = 1; c < 4; c++) begin
      adr = 6'(c * 19);
      restart({2'(c), adr});
      check(20'(o_node_addr), 20'(adr)); // address bits
      check(20'(o_speed_code), 20'(c)); // speed bits
      check(o_bit_rate, rate_of[c]); // code to rate
      check(20'(o_multidrop), 20'h0_0001); // select low
    end
  endtask

  task automatic stored_values();
    restart(8'h00);
    check(20'(o_node_addr), 20'h0_002A); // stored address
    check(o_bit_rate, 20'h0_4B00); // stored rate
    @(posedge i_ref_clk);
    alt <= 1'b1;
    repeat (3) @(negedge i_ref_clk);
    check(20'(o_node_addr), 20'h0_0015); // follows store
    check(o_bit_rate, 20'h0_E100); // follows store
    restart(8'h80);
    check(20'(o_node_addr), 20'h0_002A); // address only
    check(o_bit_rate, 20'h0_9600); // speed still used
  endtask

  task automatic hold_and_p2p();
    restart(8'h45);
    @(posedge i_ref_clk);
    sw_set   <= 8'hFF;
    i_select <= 1'b1;
    repeat (20) @(negedge i_ref_clk);
    check(20'(o_node_addr), 20'h0_0005); // held address
    check(20'(o_speed_code), 20'h0_0001); // held speed
    check(20'(o_multidrop), 20'h0_0000); // select high
    check(o_bit_rate, 20'h1_2C00); // switches ignored
    @(posedge i_ref_clk);
    i_select <= 1'b0;
    repeat (3) @(negedge i_ref_clk);
    check(o_bit_rate, 20'h0_2580); // late change ignored
  endtask

  // Bank moving just after release is taken only once it settles
  task automatic bounce_settle();
    @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    sw_set  <= 8'h41;
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    repeat (3) @(posedge i_ref_clk);
    sw_set <= 8'h83;
    for (int n = 0; n < 40; n++) begin
      @(negedge i_ref_clk);
      if (o_cfg_valid === 1'b1) break;
    end
    check(20'(o_node_addr), 20'h0_0003); // settled address
    check(o_bit_rate, 20'h0_9600); // settled speed
  endtask

  initial begin
    decode_codes();
    stored_values();
    hold_and_p2p();
    bounce_settle();
    end_of_test();
  end
endmodule
